// File: logic/rfps_defs.svh
`ifndef RFPS_DEFS_SVH
`define RFPS_DEFS_SVH

// ***************************************************************
// clock and debounce timing
// ***************************************************************
`define RFPS_CLK_MHZ 50
`define RFPS_OC_DELAY_US 100
`define RFPS_SC_DELAY_US 20
`define RFPS_OC_DELAY_CYC (`RFPS_OC_DELAY_US * `RFPS_CLK_MHZ)
`define RFPS_SC_DELAY_CYC (`RFPS_SC_DELAY_US * `RFPS_CLK_MHZ)
`define RFPS_OV_DELAY_CYC 1
`define RFPS_CNT_W 13

// ***************************************************************
// phases
// ***************************************************************
`define RFPS_CORE_CH 4
`define RFPS_PH_1 3'h1
`define RFPS_PH_2 3'h2
`define RFPS_PH_3 3'h3
`define RFPS_PH_4 3'h4

// ***************************************************************
// register offsets
// ***************************************************************
`define RFPS_ADDR_W 8
`define RFPS_OFS_CTRL 8'h00
`define RFPS_OFS_FAULT 8'h04
`define RFPS_OFS_IRQ_STATUS 8'h08
`define RFPS_OFS_IRQ_CLEAR 8'h0C
`define RFPS_OFS_IRQ_ENABLE 8'h10
`define RFPS_OFS_PHASE 8'h14

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define RFPS_CTRL_SERIAL_BIT 0
`define RFPS_CTRL_RESET 1'h0
`define RFPS_EVT_W 7
`define RFPS_EVT_CORE_OC 0
`define RFPS_EVT_CORE_SC 1
`define RFPS_EVT_CORE_OV 2
`define RFPS_EVT_AUX_OC 3
`define RFPS_EVT_AUX_SC 4
`define RFPS_EVT_AUX_OV 5
`define RFPS_EVT_PS_ENTER 6
`define RFPS_IRQ_EN_RESET 7'h00
`define RFPS_PHASE_ACT_LSB 4
`define RFPS_PHASE_PS_BIT 8
`define RFPS_PHASE_TAKEN_BIT 9

`endif

// File: logic/rfps_pkg.sv
package rfps_pkg;
   typedef enum logic {
      PS_NORMAL,
      PS_SHED
   } rfps_ps_e;
   typedef logic [2:0] rfps_phase_t;
   typedef logic [6:0] rfps_evt_t;
endpackage

// File: logic/rfps_debounce.sv
`timescale 1ns/1ps
`include "rfps_defs.svh"
module rfps_debounce
   import rfps_pkg::*;
#(
   parameter int DELAY = 1
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic level,
   output logic trip
);
   localparam logic [`RFPS_CNT_W-1:0] LAST = `RFPS_CNT_W'(DELAY - 1);
   logic [`RFPS_CNT_W-1:0] cnt;

   // ***************************************************************
   // continuous-high counter
   // ***************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= '0;
      end else if (!level) begin
         cnt <= '0; // [R18]
      end else if (cnt != LAST) begin
         cnt <= cnt + 1'b1;
      end
   end

   assign trip = level && (cnt == LAST);
endmodule

// File: logic/rfps_gate_drive.sv
`timescale 1ns/1ps
module rfps_gate_drive
#(
   parameter int CH = 1
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [CH-1:0] pwm,
   input wire logic [CH-1:0] active,
   input wire logic rail_off,
   input wire logic ov_clamp,
   output logic [CH-1:0] hs_req,
   output logic [CH-1:0] ls_req
);
   // ***************************************************************
   // per-channel request flops
   // ***************************************************************
   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : gen_ch
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               hs_req[g] <= 1'b0;
               ls_req[g] <= 1'b0;
            end else if (ov_clamp) begin
               hs_req[g] <= 1'b0;
               ls_req[g] <= 1'b1;
            end else if (rail_off || !active[g]) begin
               hs_req[g] <= 1'b0;
               ls_req[g] <= 1'b0;
            end else begin
               hs_req[g] <= pwm[g];
               ls_req[g] <= !pwm[g];
            end
         end
      end
   endgenerate
endmodule

// File: logic/rfps_top.sv
// Contract
// [R1] core over-current held for delay latches fault
// [R2] core over-current fault turns all core gates off
// [R3] core short-circuit held 20us latches fault
// [R4] core short-circuit fault turns all core gates off
// [R5] core feedback above limit latches over-voltage
// [R6] core over-voltage: low sides on, highs off
// [R7] aux over-current held 100us latches fault
// [R8] aux over-current: aux gates off, core untouched
// [R9] aux short-circuit held 20us latches fault
// [R10] aux short-circuit fault turns aux gates off
// [R11] aux feedback above limit latches over-voltage
// [R12] aux over-voltage: low side on, high off
// [R13] processor drives power-saving flag low to save
// [R14] flag taken from serial bus or pin
// [R15] saving sheds core to 1 or 2 phases
// [R16] leaving saving restores original phase count
// [R17] phase straps sampled at reset release, held
// [R18] debounce restarts when comparator drops early
// [R19] faults held until reset or enable re-rise
`timescale 1ns/1ps
`include "rfps_defs.svh"
module rfps_top
   import rfps_pkg::*;
#(
   parameter int OC_DELAY_CYC = `RFPS_OC_DELAY_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic core_oc_cmp,
   input wire logic core_sc_cmp,
   input wire logic core_ov_cmp,
   input wire logic aux_oc_cmp,
   input wire logic aux_sc_cmp,
   input wire logic aux_ov_cmp,
   input wire logic [`RFPS_CORE_CH-1:0] core_pwm,
   input wire logic aux_pwm,
   input wire logic power_saving_flag_n,
   input wire logic serial_voltage_code_bus_flag_n,
   input wire logic phase_shed_select,
   input wire logic [2:0] phase_strap,
   input wire logic [`RFPS_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic [`RFPS_CORE_CH-1:0] core_hs_req,
   output logic [`RFPS_CORE_CH-1:0] core_ls_req,
   output logic [`RFPS_CORE_CH-1:0] core_phase_active,
   output logic aux_hs_req,
   output logic aux_ls_req
);
   // ***************************************************************
   // declarations
   // ***************************************************************
   logic trip_core_oc;
   logic trip_core_sc;
   logic trip_core_ov;
   logic trip_aux_oc;
   logic trip_aux_sc;
   logic trip_aux_ov;
   logic fault_core_oc;
   logic fault_core_sc;
   logic fault_core_ov;
   logic fault_aux_oc;
   logic fault_aux_sc;
   logic fault_aux_ov;
   logic enable_q;
   logic enable_rise;
   logic ctrl_serial;
   logic strap_taken;
   rfps_phase_t base_phases;
   rfps_phase_t shed_target;
   rfps_phase_t next_active_phases;
   rfps_phase_t active_phases;
   rfps_ps_e ps_state;
   rfps_ps_e next_ps_state;
   logic psi_asserted;
   logic ps_enter;
   rfps_evt_t events;
   rfps_evt_t irq_status;
   rfps_evt_t irq_enable;
   rfps_evt_t irq_clear;
   rfps_evt_t next_irq_status;
   rfps_evt_t fault_vec;
   logic [`RFPS_CORE_CH-1:0] next_phase_mask;
   logic core_off;
   logic aux_off;
   logic [31:0] next_rdata;
   logic [31:0] phase_word;

   // ***************************************************************
   // comparator debounce
   // ***************************************************************
   rfps_debounce #(
      .DELAY(OC_DELAY_CYC)
   ) u_db_core_oc (
      .clock(clock),
      .arst_n(arst_n),
      .level(core_oc_cmp),
      .trip(trip_core_oc)
   ); // [R1]

   rfps_debounce #(
      .DELAY(`RFPS_SC_DELAY_CYC)
   ) u_db_core_sc (
      .clock(clock),
      .arst_n(arst_n),
      .level(core_sc_cmp),
      .trip(trip_core_sc)
   ); // [R3]

   rfps_debounce #(
      .DELAY(`RFPS_OV_DELAY_CYC)
   ) u_db_core_ov (
      .clock(clock),
      .arst_n(arst_n),
      .level(core_ov_cmp),
      .trip(trip_core_ov)
   ); // [R5]

   rfps_debounce #(
      .DELAY(OC_DELAY_CYC)
   ) u_db_aux_oc (
      .clock(clock),
      .arst_n(arst_n),
      .level(aux_oc_cmp),
      .trip(trip_aux_oc)
   ); // [R7]

   rfps_debounce #(
      .DELAY(`RFPS_SC_DELAY_CYC)
   ) u_db_aux_sc (
      .clock(clock),
      .arst_n(arst_n),
      .level(aux_sc_cmp),
      .trip(trip_aux_sc)
   ); // [R9]

   rfps_debounce #(
      .DELAY(`RFPS_OV_DELAY_CYC)
   ) u_db_aux_ov (
      .clock(clock),
      .arst_n(arst_n),
      .level(aux_ov_cmp),
      .trip(trip_aux_ov)
   ); // [R11]

   // ***************************************************************
   // enable edge
   // ***************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         enable_q <= 1'b0;
      end else begin
         enable_q <= enable;
      end
   end

   assign enable_rise = enable && !enable_q;

   // ***************************************************************
   // fault latches, set wins over clear
   // ***************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fault_core_oc <= 1'b0;
         fault_core_sc <= 1'b0;
         fault_core_ov <= 1'b0;
      end else begin
         fault_core_oc <= trip_core_oc || (fault_core_oc && !enable_rise); // [R1] [R19]
         fault_core_sc <= trip_core_sc || (fault_core_sc && !enable_rise); // [R3] [R19]
         fault_core_ov <= trip_core_ov || (fault_core_ov && !enable_rise); // [R5] [R19]
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fault_aux_oc <= 1'b0;
         fault_aux_sc <= 1'b0;
         fault_aux_ov <= 1'b0;
      end else begin
         fault_aux_oc <= trip_aux_oc || (fault_aux_oc && !enable_rise); // [R7] [R19]
         fault_aux_sc <= trip_aux_sc || (fault_aux_sc && !enable_rise); // [R9] [R19]
         fault_aux_ov <= trip_aux_ov || (fault_aux_ov && !enable_rise); // [R11] [R19]
      end
   end

   assign fault_vec = {1'b0, fault_aux_ov, fault_aux_sc, fault_aux_oc,
                       fault_core_ov, fault_core_sc, fault_core_oc};

   // ***************************************************************
   // phase strap capture at reset release
   // ***************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         strap_taken <= 1'b0;
         base_phases <= `RFPS_PH_4;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1; // [R17]
         if (phase_strap[0]) begin
            base_phases <= `RFPS_PH_1;
         end else if (phase_strap[1]) begin
            base_phases <= `RFPS_PH_2;
         end else if (phase_strap[2]) begin
            base_phases <= `RFPS_PH_3;
         end else begin
            base_phases <= `RFPS_PH_4;
         end
      end
   end

   // ***************************************************************
   // power-saving control
   // ***************************************************************
   assign psi_asserted = ctrl_serial ? !serial_voltage_code_bus_flag_n
                                     : !power_saving_flag_n; // [R13] [R14]
   assign shed_target = phase_shed_select ? `RFPS_PH_2 : `RFPS_PH_1;

   always_comb begin
      next_ps_state = ps_state;
      case (ps_state)
         PS_NORMAL: begin
            if (psi_asserted) begin
               next_ps_state = PS_SHED;
            end
         end
         PS_SHED: begin
            if (!psi_asserted) begin
               next_ps_state = PS_NORMAL; // [R16]
            end
         end
         default: begin
            next_ps_state = PS_NORMAL;
         end
      endcase
   end

   assign ps_enter = (ps_state == PS_NORMAL) && (next_ps_state == PS_SHED);

   always_comb begin
      if (ps_state == PS_SHED && shed_target < base_phases) begin
         next_active_phases = shed_target; // [R15]
      end else begin
         next_active_phases = base_phases; // [R16]
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ps_state <= PS_NORMAL;
         active_phases <= `RFPS_PH_4;
      end else begin
         ps_state <= next_ps_state;
         active_phases <= next_active_phases;
      end
   end

   // ***************************************************************
   // active channel mask
   // ***************************************************************
   genvar gc;
   generate
      for (gc = 0; gc < `RFPS_CORE_CH; gc++) begin : gen_mask
         assign next_phase_mask[gc] = strap_taken &&
            (active_phases > 3'(gc)); // [R15] [R16]
      end
   endgenerate

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         core_phase_active <= '0;
      end else begin
         core_phase_active <= next_phase_mask;
      end
   end

   // ***************************************************************
   // gate requests
   // ***************************************************************
   assign core_off = fault_core_oc || fault_core_sc || !enable; // [R2] [R4]
   assign aux_off = fault_aux_oc || fault_aux_sc || !enable; // [R8] [R10]

   rfps_gate_drive #(
      .CH(`RFPS_CORE_CH)
   ) u_core_drive (
      .clock(clock),
      .arst_n(arst_n),
      .pwm(core_pwm),
      .active(core_phase_active),
      .rail_off(core_off), // [R2] [R4]
      .ov_clamp(fault_core_ov), // [R6]
      .hs_req(core_hs_req),
      .ls_req(core_ls_req)
   );

   rfps_gate_drive #(
      .CH(1)
   ) u_aux_drive (
      .clock(clock),
      .arst_n(arst_n),
      .pwm(aux_pwm),
      .active(strap_taken),
      .rail_off(aux_off), // [R8] [R10]
      .ov_clamp(fault_aux_ov), // [R12]
      .hs_req(aux_hs_req),
      .ls_req(aux_ls_req)
   );

   // ***************************************************************
   // interrupt status, clear and enable
   // ***************************************************************
   always_comb begin
      events = '0;
      events[`RFPS_EVT_CORE_OC] = trip_core_oc && !fault_core_oc;
      events[`RFPS_EVT_CORE_SC] = trip_core_sc && !fault_core_sc;
      events[`RFPS_EVT_CORE_OV] = trip_core_ov && !fault_core_ov;
      events[`RFPS_EVT_AUX_OC] = trip_aux_oc && !fault_aux_oc;
      events[`RFPS_EVT_AUX_SC] = trip_aux_sc && !fault_aux_sc;
      events[`RFPS_EVT_AUX_OV] = trip_aux_ov && !fault_aux_ov;
      events[`RFPS_EVT_PS_ENTER] = ps_enter;
   end

   always_comb begin
      irq_clear = '0;
      if (reg_write && reg_addr == `RFPS_OFS_IRQ_CLEAR) begin
         irq_clear = reg_wdata[`RFPS_EVT_W-1:0];
      end
   end

   assign next_irq_status = (irq_status & ~irq_clear) | events;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= '0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_enable <= `RFPS_IRQ_EN_RESET;
      end else if (reg_write && reg_addr == `RFPS_OFS_IRQ_ENABLE) begin
         irq_enable <= reg_wdata[`RFPS_EVT_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else if (reg_write && reg_addr == `RFPS_OFS_IRQ_ENABLE) begin
         irq <= |(next_irq_status & reg_wdata[`RFPS_EVT_W-1:0]);
      end else begin
         irq <= |(next_irq_status & irq_enable);
      end
   end

   // ***************************************************************
   // control register
   // ***************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_serial <= `RFPS_CTRL_RESET;
      end else if (reg_write && reg_addr == `RFPS_OFS_CTRL) begin
         ctrl_serial <= reg_wdata[`RFPS_CTRL_SERIAL_BIT]; // [R14]
      end
   end

   // ***************************************************************
   // read port
   // ***************************************************************
   always_comb begin
      phase_word = '0;
      phase_word[2:0] = base_phases;
      phase_word[`RFPS_PHASE_ACT_LSB +: 3] = active_phases;
      phase_word[`RFPS_PHASE_PS_BIT] = (ps_state == PS_SHED);
      phase_word[`RFPS_PHASE_TAKEN_BIT] = strap_taken;
   end

   always_comb begin
      next_rdata = '0;
      if (reg_read) begin
         case (reg_addr)
            `RFPS_OFS_CTRL: begin
               next_rdata[`RFPS_CTRL_SERIAL_BIT] = ctrl_serial;
            end
            `RFPS_OFS_FAULT: begin
               next_rdata[`RFPS_EVT_W-1:0] = fault_vec;
            end
            `RFPS_OFS_IRQ_STATUS: begin
               next_rdata[`RFPS_EVT_W-1:0] = irq_status;
            end
            `RFPS_OFS_IRQ_ENABLE: begin
               next_rdata[`RFPS_EVT_W-1:0] = irq_enable;
            end
            `RFPS_OFS_PHASE: begin
               next_rdata = phase_word;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule

// File: dv/rfps_checker.sv
`timescale 1ns/1ps
`include "rfps_defs.svh"
module rfps_checker
#(
   parameter int OC_DELAY_CYC = 5000
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic core_oc_cmp,
   input wire logic core_sc_cmp,
   input wire logic core_ov_cmp,
   input wire logic aux_oc_cmp,
   input wire logic aux_sc_cmp,
   input wire logic aux_ov_cmp,
   input wire logic power_saving_flag_n,
   input wire logic serial_voltage_code_bus_flag_n,
   input wire logic phase_shed_select,
   input wire logic [2:0] phase_strap,
   input wire logic [`RFPS_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic [`RFPS_CORE_CH-1:0] core_hs_req,
   input wire logic [`RFPS_CORE_CH-1:0] core_ls_req,
   input wire logic [`RFPS_CORE_CH-1:0] core_phase_active,
   input wire logic aux_hs_req,
   input wire logic aux_ls_req
);
   localparam int SC_N = `RFPS_SC_DELAY_CYC;
   logic [12:0] run_co, run_cs, run_ao, run_as;
   logic src_bus, taken, shed_n;
   logic [3:0] base_mask;
   assign shed_n = src_bus ? serial_voltage_code_bus_flag_n
      : power_saving_flag_n;
   // ********
   // run lengths, strap, flag source
   // ********
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         run_co <= 13'h0;
         run_cs <= 13'h0;
         run_ao <= 13'h0;
         run_as <= 13'h0;
      end else begin
         run_co <= core_oc_cmp ? run_co + 13'h1 : 13'h0;
         run_cs <= core_sc_cmp ? run_cs + 13'h1 : 13'h0;
         run_ao <= aux_oc_cmp ? run_ao + 13'h1 : 13'h0;
         run_as <= aux_sc_cmp ? run_as + 13'h1 : 13'h0;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         taken <= 1'b0;
         base_mask <= 4'h0;
      end else if (!taken) begin
         taken <= 1'b1;
         base_mask <= phase_strap[0] ? 4'h1 : phase_strap[1] ? 4'h3
            : phase_strap[2] ? 4'h7 : 4'hf;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         src_bus <= 1'b0;
      end else if (reg_write && reg_addr == `RFPS_OFS_CTRL) begin
         src_bus <= reg_wdata[`RFPS_CTRL_SERIAL_BIT];
      end
   end
   // ********
   // properties
   // ********
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   sequence s_held;
      enable ##1 enable;
   endsequence
   sequence s_saving(sel);
      (!shed_n && phase_shed_select == sel) [*3];
   endsequence
   chk_core_oc_off: assert property (
      (run_co == OC_DELAY_CYC - 1 && core_oc_cmp) ##0 s_held
      |=> core_hs_req == 4'h0)
      else $error("core gates on after over-current");
   chk_core_sc_off: assert property (
      (run_cs == SC_N - 1 && core_sc_cmp) ##0 s_held
      |=> core_hs_req == 4'h0)
      else $error("core gates on after short-circuit");
   chk_core_ov_clamp: assert property (
      core_ov_cmp ##0 s_held
      |=> core_hs_req == 4'h0 && core_ls_req == 4'hf)
      else $error("core clamp missing after over-voltage");
   chk_aux_oc_off: assert property (
      (run_ao == OC_DELAY_CYC - 1 && aux_oc_cmp) ##0 s_held
      |=> !aux_hs_req)
      else $error("aux high side on after over-current");
   chk_aux_sc_off: assert property (
      (run_as == SC_N - 1 && aux_sc_cmp) ##0 s_held |=> !aux_hs_req)
      else $error("aux high side on after short-circuit");
   chk_aux_ov_clamp: assert property (
      aux_ov_cmp ##0 s_held |=> !aux_hs_req && aux_ls_req)
      else $error("aux clamp missing after over-voltage");
   chk_shed_one: assert property (
      s_saving(1'b0) |=> core_phase_active[3:1] == 3'h0)
      else $error("more than one phase while saving");
   chk_shed_two: assert property (
      s_saving(1'b1) |=> core_phase_active[3:2] == 2'h0)
      else $error("more than two phases while saving");
   chk_phase_restore: assert property (
      (shed_n && taken) [*3] |=> core_phase_active == base_mask)
      else $error("phase mask differs from strapped count");
endmodule

bind rfps_top rfps_checker #(.OC_DELAY_CYC(OC_DELAY_CYC)) i_rfps_checker (
   .clock(clock), .arst_n(arst_n), .enable(enable),
   .core_oc_cmp(core_oc_cmp), .core_sc_cmp(core_sc_cmp),
   .core_ov_cmp(core_ov_cmp), .aux_oc_cmp(aux_oc_cmp),
   .aux_sc_cmp(aux_sc_cmp), .aux_ov_cmp(aux_ov_cmp),
   .power_saving_flag_n(power_saving_flag_n),
   .serial_voltage_code_bus_flag_n(serial_voltage_code_bus_flag_n),
   .phase_shed_select(phase_shed_select), .phase_strap(phase_strap),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .core_hs_req(core_hs_req), .core_ls_req(core_ls_req),
   .core_phase_active(core_phase_active),
   .aux_hs_req(aux_hs_req), .aux_ls_req(aux_ls_req)
);

// File: dv/rfps_partner.sv
`timescale 1ns/1ps
module rfps_partner (
   input wire logic clock,
   input wire logic [3:0] core_hs,
   input wire logic [3:0] core_ls,
   input wire logic aux_hs,
   input wire logic aux_ls,
   output logic [5:0] cmp,
   output logic [3:0] core_pwm,
   output logic aux_pwm,
   output logic pin_n,
   output logic bus_n,
   output logic two,
   output logic [2:0] strap,
   output logic shoot
);
   // ********
   // comparators, pwm and power-saving flag
   // ********
   initial begin
      cmp = 6'h00;
      core_pwm = 4'h5;
      aux_pwm = 1'b1;
      pin_n = 1'b1;
      bus_n = 1'b1;
      two = 1'b0;
      strap = 3'h0;
      shoot = 1'b0;
   end
   task hold(input int idx, input int n);
      @(posedge clock);
      cmp[idx] <= 1'b1;
      repeat (n) @(posedge clock);
      cmp[idx] <= 1'b0;
   endtask
   task save(input logic on_bus, input logic act);
      @(posedge clock);
      if (on_bus) begin
         bus_n <= !act;
      end else begin
         pin_n <= !act;
      end
   endtask
   // ********
   // driver shoot-through watch
   // ********
   always @(posedge clock) begin
      if ((core_hs & core_ls) != 4'h0 || (aux_hs && aux_ls)) begin
         shoot <= 1'b1;
      end
   end
endmodule

// File: dv/rfps_top_tb.sv
`timescale 1ns/1ps
`include "rfps_defs.svh"
module rfps_top_tb;
   localparam int OC_N = 20;
   localparam logic [9:0] RUN = 10'h16a;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic enable = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic irq, aux_hs_req, aux_ls_req, aux_pwm, pin_n, bus_n, two, shoot;
   logic [5:0] cmp;
   logic [3:0] core_pwm, core_hs_req, core_ls_req, core_phase_active;
   logic [2:0] strap;
   logic [9:0] gates;
   int num_errors = 0;
   int n_tests = 0;
   int dly [6] = '{OC_N, `RFPS_SC_DELAY_CYC, 1, OC_N, `RFPS_SC_DELAY_CYC, 1};
   logic [9:0] hit [6] = '{10'h002, 10'h002, 10'h03e, 10'h168, 10'h168,
      10'h169};
   assign gates = {core_hs_req, core_ls_req, aux_hs_req, aux_ls_req};
   always #10 clock = ~clock;
   rfps_top #(.OC_DELAY_CYC(OC_N)) i_rfps_top (
      .clock(clock), .arst_n(arst_n), .enable(enable),
      .core_oc_cmp(cmp[0]), .core_sc_cmp(cmp[1]), .core_ov_cmp(cmp[2]),
      .aux_oc_cmp(cmp[3]), .aux_sc_cmp(cmp[4]), .aux_ov_cmp(cmp[5]),
      .core_pwm(core_pwm), .aux_pwm(aux_pwm),
      .power_saving_flag_n(pin_n), .serial_voltage_code_bus_flag_n(bus_n),
      .phase_shed_select(two), .phase_strap(strap),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
      .core_hs_req(core_hs_req), .core_ls_req(core_ls_req),
      .core_phase_active(core_phase_active),
      .aux_hs_req(aux_hs_req), .aux_ls_req(aux_ls_req)
   );
   rfps_partner i_rfps_partner (
      .clock(clock), .core_hs(core_hs_req), .core_ls(core_ls_req),
      .aux_hs(aux_hs_req), .aux_ls(aux_ls_req), .cmp(cmp),
      .core_pwm(core_pwm), .aux_pwm(aux_pwm), .pin_n(pin_n),
      .bus_n(bus_n), .two(two), .strap(strap), .shoot(shoot)
   );
   // ********
   // shared tasks
   // ********
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
         input string what);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      check(what, reg_rdata, exp);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wait_irq;
      for (int k = 0; k < 10 && irq !== 1'b1; k++) begin
         tick(1);
      end
      check("irq", irq, 32'h1);
      if (irq !== 1'b1) begin
         close_out();
      end
   endtask
   // ********
   // main sequence
   // ********
   initial begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      enable <= 1'b1;
      @(posedge clock);
      i_rfps_partner.strap <= 3'h1;
      tick(4);
      rdc(`RFPS_OFS_PHASE, 32'h0000_0244, "phase");
      check("active", core_phase_active, 4'hf);
      check("gates", gates, RUN);
      rdc(`RFPS_OFS_CTRL, '0, "ctrl");
      rdc(`RFPS_OFS_IRQ_ENABLE, '0, "irq enable");
      rdc(`RFPS_OFS_IRQ_CLEAR, '0, "irq clear");
      rdc(8'h40, '0, "unmapped");
      wr(`RFPS_OFS_PHASE, 32'h0000_0001);
      rdc(`RFPS_OFS_PHASE, 32'h0000_0244, "phase ro");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         if (dly[i] > 1) begin
            i_rfps_partner.hold(i, dly[i] - 1);
            tick(1);
            i_rfps_partner.hold(i, dly[i] - 1);
            tick(3);
            rdc(`RFPS_OFS_FAULT, '0, "early");
         end
         i_rfps_partner.hold(i, dly[i]);
         tick(3);
         check("gates", gates, hit[i]);
         rdc(`RFPS_OFS_FAULT, 32'h1 << i, "fault");
         check("masked", irq, '0);
         wr(`RFPS_OFS_IRQ_ENABLE, 32'h0000_007f);
         wait_irq();
         @(posedge clock);
         enable <= 1'b0;
         @(posedge clock);
         enable <= 1'b1;
         wr(`RFPS_OFS_IRQ_CLEAR, 32'h0000_007f);
         tick(4);
         check("irq off", irq, '0);
         check("gates", gates, RUN);
         rdc(`RFPS_OFS_FAULT, '0, "cleared");
         wr(`RFPS_OFS_IRQ_ENABLE, '0);
      end
      $display("test faults done");
      i_rfps_partner.save(1'b0, 1'b1);
      tick(4);
      check("one", core_phase_active, 4'h1);
      check("gates", gates, 10'h042);
      rdc(`RFPS_OFS_IRQ_STATUS, 32'h0000_0040, "saving event");
      @(posedge clock);
      i_rfps_partner.two <= 1'b1;
      tick(4);
      check("two", core_phase_active, 4'h3);
      i_rfps_partner.save(1'b0, 1'b0);
      tick(4);
      check("back", core_phase_active, 4'hf);
      wr(`RFPS_OFS_CTRL, 32'h0000_0001);
      i_rfps_partner.save(1'b0, 1'b1);
      tick(4);
      check("pin ignored", core_phase_active, 4'hf);
      i_rfps_partner.save(1'b1, 1'b1);
      tick(4);
      check("bus", core_phase_active, 4'h3);
      i_rfps_partner.save(1'b1, 1'b0);
      tick(4);
      check("bus back", core_phase_active, 4'hf);
      check("overlap", shoot, '0);
      $display("test power saving done");
      close_out();
   end
endmodule
